// *** design/haptic_port_slave.sv ***
// Slave end of the haptic driver two-wire register port, with its map.
// Assumes status inputs come from logic on sys_clk; bus pins do not.
//
// Overview of operation
// [R1] Data changes only while clock is low
// [R2] Data falling with clock high starts
// [R3] Data rising with clock high stops
// [R4] Repeated start behaves exactly like start
// [R5] Nine clocks per unit, MSB first
// [R6] Acknowledge is data low in ninth clock
// [R7] First byte: 7-bit address plus direction
// [R8] Write: register address follows, acknowledged
// [R9] Data bytes stored, pointer advances by one
// [R10] Reads: set address, restart, address read
// [R11] Read returns byte, pointer advances each slot
// [R12] Unlimited bytes between start and stop
// [R13] Key 0xAA at 0x00 restores defaults
// [R14] Host never writes reserved registers
// [R15] Identity register 0x64 holds two bits
// [R16] Answers only to fixed address 0x58
// [R17] Latched bits set from live, read clears
// [R18] Unmasked latched bit pulls interrupt low
// [R19] Foreign address: no acknowledge, ignore bus
`timescale 1ns/100ps
module haptic_port_slave #(
    // Identity bits: arbitrary values
    parameter logic IDENTITY_HIGH = 1'b0,
    parameter logic IDENTITY_LOW = 1'b0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Bus
    two_wire_bus.slave bus,
    // Status from the driver core
    input wire logic [5:0] status_live,
    input wire logic ldo_ok,
    input wire logic [31:0] f0_readback,
    input wire logic [3:0] engine_state,
    // Configuration towards the driver core
    output logic [haptic_port_pkg::REG_COUNT-1:0][7:0] cfg_reg
);
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_RX = 6'b000010,
        S_ACK = 6'b000100,
        S_TX = 6'b001000,
        S_RACK = 6'b010000,
        S_SKIP = 6'b100000
    } slave_state_e;

    typedef enum logic [2:0] {
        K_ADDR = 3'b001,
        K_REG = 3'b010,
        K_DATA = 3'b100
    } byte_kind_e;

    slave_state_e state_reg;
    byte_kind_e kind_reg;
    logic [1:0] pins_q;
    logic scl_q;
    logic sda_q;
    logic scl_d_reg;
    logic sda_d_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [3:0] cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] ptr_reg;
    logic rw_reg;
    logic nack_reg;
    logic drive_reg;
    logic irq_reg;
    logic [5:0] latched_reg;
    logic byte_done;
    logic store;
    logic load;
    logic [7:0] rd_byte;

    two_flop_sync #(
        .WIDTH(2)
    ) u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .d({bus.scl, bus.sda}),
        .q(pins_q)
    );

    assign scl_q = pins_q[1];
    assign sda_q = pins_q[0];

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_q;
            sda_d_reg <= sda_q;
        end
    end

    // Bus events; data moving with clock high marks framing
    assign scl_rise = scl_q && !scl_d_reg;
    assign scl_fall = !scl_q && scl_d_reg;
    assign start_seen = scl_q && scl_d_reg && sda_d_reg && !sda_q; // [R2]
    assign stop_seen = scl_q && scl_d_reg && !sda_d_reg && sda_q; // [R3]

    assign byte_done = (state_reg == S_RX) && scl_fall
        && (cnt_reg == haptic_port_pkg::BITS_PER_UNIT);
    assign store = byte_done && (kind_reg == K_DATA);
    assign load = scl_fall && (((state_reg == S_ACK) && (kind_reg == K_ADDR)
        && rw_reg) || ((state_reg == S_RACK) && !nack_reg));

    function automatic logic [7:0] read_mux(
        input logic [7:0] off,
        input logic [haptic_port_pkg::REG_COUNT-1:0][7:0] cfg,
        input logic [5:0] live,
        input logic [5:0] latched,
        input logic ldo,
        input logic [31:0] f0,
        input logic [3:0] engine
    );
        logic [7:0] val;
        val = 8'h00;
        case (off)
            haptic_port_pkg::OFF_LIVE_STATUS: val = {2'h0, live};
            haptic_port_pkg::OFF_LATCHED_INT: val = {2'h0, latched};
            haptic_port_pkg::OFF_REGULATOR:
                val = {4'h0, ldo, haptic_port_pkg::REGULATOR_LOW_BITS};
            haptic_port_pkg::OFF_MEAS_F0_HI: val = f0[31:24];
            haptic_port_pkg::OFF_MEAS_F0_LO: val = f0[23:16];
            haptic_port_pkg::OFF_TRACK_F0_HI: val = f0[15:8];
            haptic_port_pkg::OFF_TRACK_F0_LO: val = f0[7:0];
            haptic_port_pkg::OFF_ENGINE_STATE: val = {4'h0, engine};
            haptic_port_pkg::OFF_IDENTITY:
                val = {6'h00, IDENTITY_HIGH, IDENTITY_LOW}; // [R15]
            default: begin
                if (haptic_port_pkg::reg_writable(off)) begin
                    val = cfg[off[6:0]];
                end
            end
        endcase
        return val;
    endfunction

    always_comb begin
        rd_byte = read_mux(ptr_reg, cfg_reg, status_live, latched_reg,
            ldo_ok, f0_readback, engine_state);
    end

    // Byte and acknowledge sequencing
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= S_IDLE;
            kind_reg <= K_ADDR;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            rw_reg <= 1'b0;
            nack_reg <= 1'b0;
            drive_reg <= 1'b0;
        end else if (start_seen) begin
            state_reg <= S_RX; // [R4]
            kind_reg <= K_ADDR;
            cnt_reg <= 4'h0;
            drive_reg <= 1'b0;
        end else if (stop_seen) begin
            state_reg <= S_IDLE;
            drive_reg <= 1'b0;
        end else begin
            case (state_reg)
                S_RX: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_q}; // [R5]
                        cnt_reg <= cnt_reg + 4'h1;
                    end else if (byte_done) begin
                        cnt_reg <= 4'h0;
                        if (kind_reg != K_ADDR) begin
                            drive_reg <= 1'b1; // [R8]
                            state_reg <= S_ACK;
                        end else if (shift_reg[7:1]
                                == haptic_port_pkg::DEV_ADDR) begin // [R16]
                            rw_reg <= shift_reg[0]; // [R7]
                            drive_reg <= 1'b1; // [R6]
                            state_reg <= S_ACK;
                        end else begin
                            state_reg <= S_SKIP; // [R19]
                        end
                    end
                end
                S_ACK: begin
                    if (load) begin
                        shift_reg <= rd_byte;
                        drive_reg <= !rd_byte[7]; // [R1]
                        state_reg <= S_TX;
                    end else if (scl_fall) begin
                        drive_reg <= 1'b0;
                        state_reg <= S_RX;
                        kind_reg <= (kind_reg == K_ADDR) ? K_REG : K_DATA;
                    end
                end
                S_TX: begin
                    if (scl_rise) begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_reg == haptic_port_pkg::BITS_PER_UNIT) begin
                            cnt_reg <= 4'h0;
                            drive_reg <= 1'b0;
                            state_reg <= S_RACK;
                        end else begin
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            drive_reg <= !shift_reg[6]; // [R1]
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise) begin
                        nack_reg <= sda_q; // [R6]
                    end else if (load) begin
                        shift_reg <= rd_byte; // [R11]
                        drive_reg <= !rd_byte[7];
                        state_reg <= S_TX;
                    end else if (scl_fall) begin
                        state_reg <= S_SKIP;
                    end
                end
                S_SKIP: state_reg <= S_SKIP;
                S_IDLE: state_reg <= S_IDLE;
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // Register pointer: wraps, so transfers never run out
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr_reg <= 8'h00;
        end else if (byte_done && (kind_reg == K_REG)) begin
            ptr_reg <= shift_reg; // [R8]
        end else if (store) begin
            ptr_reg <= ptr_reg + 8'h01; // [R9] [R12]
        end else if ((state_reg == S_RACK) && scl_rise) begin
            ptr_reg <= ptr_reg + 8'h01; // [R11] [R12]
        end
    end

    // Configuration store and soft reset
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < haptic_port_pkg::REG_COUNT; i++) begin
                cfg_reg[i] <= haptic_port_pkg::reg_default(8'(i));
            end
        end else if (store && (ptr_reg == haptic_port_pkg::OFF_SOFT_RESET)
                && (shift_reg == haptic_port_pkg::SOFT_RESET_KEY)) begin
            for (int i = 0; i < haptic_port_pkg::REG_COUNT; i++) begin
                cfg_reg[i] <= haptic_port_pkg::reg_default(8'(i)); // [R13]
            end
        end else if (store && haptic_port_pkg::reg_writable(ptr_reg)) begin
            cfg_reg[ptr_reg[6:0]] <= shift_reg; // [R9]
        end
    end

    // Latched interrupts: a new event beats the read clear
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            latched_reg <= haptic_port_pkg::LATCHED_RST;
        end else if (load && (ptr_reg == haptic_port_pkg::OFF_LATCHED_INT)) begin
            latched_reg <= status_live; // [R17]
        end else begin
            latched_reg <= latched_reg | status_live; // [R17]
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(latched_reg
                & ~cfg_reg[haptic_port_pkg::OFF_INT_MASKS][5:0]); // [R18]
        end
    end

    assign bus.sda_s_o = 1'b0;
    assign bus.sda_s_oe = drive_reg;
    assign bus.irq_s_o = 1'b0;
    assign bus.irq_s_oe = irq_reg;
endmodule // haptic_port_slave

// *** shared/haptic_port_pkg.sv ***
// Shared constants for the haptic driver two-wire register port.
// Assumes a 50 MHz system clock on both ends of the bus.
package haptic_port_pkg;

    // Bus addressing and framing
    localparam logic [6:0] DEV_ADDR = 7'h58;
    localparam logic [7:0] SOFT_RESET_KEY = 8'hAA;
    localparam logic [3:0] BITS_PER_UNIT = 4'h8;
    localparam int REG_COUNT = 128;

    // Offsets with special behaviour
    localparam logic [7:0] OFF_SOFT_RESET = 8'h00;
    localparam logic [7:0] OFF_LIVE_STATUS = 8'h01;
    localparam logic [7:0] OFF_LATCHED_INT = 8'h02;
    localparam logic [7:0] OFF_INT_MASKS = 8'h03;
    localparam logic [7:0] OFF_REGULATOR = 8'h04;
    localparam logic [7:0] OFF_MEAS_F0_HI = 8'h25;
    localparam logic [7:0] OFF_MEAS_F0_LO = 8'h26;
    localparam logic [7:0] OFF_TRACK_F0_HI = 8'h27;
    localparam logic [7:0] OFF_TRACK_F0_LO = 8'h28;
    localparam logic [7:0] OFF_ENGINE_STATE = 8'h3F;
    localparam logic [7:0] OFF_IDENTITY = 8'h64;

    // Reset values of status registers
    localparam logic [5:0] LATCHED_RST = 6'h10;
    localparam logic [2:0] REGULATOR_LOW_BITS = 3'h1;

    // Writable registers: offsets and reset values, index for index
    localparam int RW_COUNT = 39;
    localparam logic [7:0] RW_OFFS [RW_COUNT] = '{
        8'h03, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D,
        8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
        8'h16, 8'h18, 8'h19, 8'h1A, 8'h1C, 8'h1D, 8'h1E, 8'h1F,
        8'h20, 8'h21, 8'h22, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31,
        8'h32, 8'h33, 8'h36, 8'h39, 8'h3A, 8'h3C, 8'h3E};
    localparam logic [7:0] RW_DEFS [RW_COUNT] = '{
        8'h3F, 8'h80, 8'h04, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'hE1, 8'h8D, 8'h6A, 8'h08, 8'hFF, 8'h50, 8'h04,
        8'h06, 8'h08, 8'h0F, 8'h38, 8'h00, 8'h26, 8'h00, 8'h00,
        8'h00, 8'h01, 8'h01, 8'h22, 8'h20, 8'h04, 8'h1B};

    // Bus timing: fast mode, quarter of a 2500 ns bit period
    localparam int SYS_CLK_NS = 20;
    localparam int SCL_QUARTER_NS = 625;
    localparam int SCL_QUARTER_CYCLES =
        (SCL_QUARTER_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

    function automatic logic reg_writable(input logic [7:0] off);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < RW_COUNT; i++) begin
            if (RW_OFFS[i] == off) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    function automatic logic [7:0] reg_default(input logic [7:0] off);
        logic [7:0] val;
        val = 8'h00;
        for (int i = 0; i < RW_COUNT; i++) begin
            if (RW_OFFS[i] == off) begin
                val = RW_DEFS[i];
            end
        end
        return val;
    endfunction

endpackage

// *** shared/two_wire_bus.sv ***
// Open-drain two-wire bus plus interrupt line between master and slave.
// Resolves wire levels from output enables; pull-ups assumed.
`timescale 1ns/100ps
interface two_wire_bus;
    logic scl_m_o;
    logic scl_m_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic irq_s_o;
    logic irq_s_oe;
    logic scl;
    logic sda;
    logic interrupt_out_n;

    assign scl = !(scl_m_oe && !scl_m_o);
    assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
    assign interrupt_out_n = !(irq_s_oe && !irq_s_o);

    modport master (
        output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe,
        input scl, sda, interrupt_out_n
    );
    modport slave (
        output sda_s_o, sda_s_oe, irq_s_o, irq_s_oe,
        input scl, sda
    );
endinterface

// *** design/two_flop_sync.sv ***
// Two-stage synchroniser for levels arriving from pins.
// Assumes inputs change slowly relative to sys_clk.
`timescale 1ns/100ps
module two_flop_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= '1;
            q <= '1;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // two_flop_sync

// *** design/haptic_port_master.sv ***
// Master end of the two-wire register port: one-byte writes and reads.
// Assumes a single slave at the fixed address; pins are open-drain.
`timescale 1ns/100ps
module haptic_port_master #(
    parameter int QUARTER = haptic_port_pkg::SCL_QUARTER_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Bus
    two_wire_bus.master bus,
    // Command
    input wire logic cmd_valid,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_reg_addr,
    input wire logic [7:0] cmd_wdata,
    output logic cmd_ready,
    // Response
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_nack,
    output logic irq_seen
);
    typedef enum logic [3:0] {
        SYM_START = 4'b0001,
        SYM_TX = 4'b0010,
        SYM_RX = 4'b0100,
        SYM_STOP = 4'b1000
    } symbol_e;

    logic [1:0] pins_q;
    logic [7:0] qcnt_reg;
    logic [1:0] ph_reg;
    logic [3:0] bit_reg;
    logic [2:0] step_reg;
    logic read_reg;
    logic [7:0] reg_addr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] tx_reg;
    logic scl_oe_reg;
    logic sda_oe_reg;
    logic tick;
    symbol_e sym;
    logic [2:0] last_step;

    function automatic symbol_e step_symbol(input logic rd,
            input logic [2:0] st);
        symbol_e s;
        s = SYM_TX;
        if (st == 3'h0 || (rd && st == 3'h3)) begin
            s = SYM_START; // [R10]
        end else if ((rd && st == 3'h6) || (!rd && st == 3'h4)) begin
            s = SYM_STOP;
        end else if (rd && st == 3'h5) begin
            s = SYM_RX;
        end
        return s;
    endfunction

    function automatic logic [7:0] step_byte(input logic [2:0] st,
            input logic [7:0] ra, input logic [7:0] wd);
        logic [7:0] b;
        case (st)
            3'h1: b = {haptic_port_pkg::DEV_ADDR, 1'b0}; // [R7]
            3'h2: b = ra; // [R8]
            3'h3: b = wd;
            3'h4: b = {haptic_port_pkg::DEV_ADDR, 1'b1}; // [R10]
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    two_flop_sync #(
        .WIDTH(2)
    ) u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .d({bus.sda, bus.interrupt_out_n}),
        .q(pins_q)
    );

    assign tick = (qcnt_reg == 8'(QUARTER - 1));
    assign last_step = read_reg ? 3'h6 : 3'h4;

    always_comb begin
        sym = step_symbol(read_reg, step_reg);
    end

    // Quarter-period divider makes the bus clock
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            qcnt_reg <= 8'h00;
        end else if (cmd_ready || tick) begin
            qcnt_reg <= 8'h00;
        end else begin
            qcnt_reg <= qcnt_reg + 8'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_ready <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_nack <= 1'b0;
            ph_reg <= 2'h0;
            bit_reg <= 4'h0;
            step_reg <= 3'h0;
            read_reg <= 1'b0;
            reg_addr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            tx_reg <= 8'h00;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else if (cmd_ready) begin
            rsp_valid <= 1'b0;
            if (cmd_valid) begin
                cmd_ready <= 1'b0;
                read_reg <= cmd_read;
                reg_addr_reg <= cmd_reg_addr;
                wdata_reg <= cmd_wdata;
                rsp_nack <= 1'b0;
                step_reg <= 3'h0;
                ph_reg <= 2'h0;
                bit_reg <= 4'h0;
            end
        end else if (tick) begin
            ph_reg <= ph_reg + 2'h1;
            case (ph_reg)
                2'h0: begin
                    // Data moves only while the clock is held low [R1]
                    if (sym == SYM_START) begin
                        sda_oe_reg <= 1'b0;
                    end else if (sym == SYM_STOP) begin
                        sda_oe_reg <= 1'b1;
                    end else if (bit_reg == 4'h8) begin
                        sda_oe_reg <= 1'b0; // [R6]
                    end else begin
                        sda_oe_reg <= (sym == SYM_TX) && !tx_reg[7]; // [R5]
                    end
                end
                2'h1: scl_oe_reg <= 1'b0;
                2'h2: begin
                    if (sym == SYM_START) begin
                        sda_oe_reg <= 1'b1; // [R2]
                    end else if (sym == SYM_STOP) begin
                        sda_oe_reg <= 1'b0; // [R3]
                    end else if (bit_reg == 4'h8) begin
                        if (sym == SYM_TX && pins_q[1]) begin
                            rsp_nack <= 1'b1; // [R6]
                        end
                    end else if (sym == SYM_RX) begin
                        rsp_data <= {rsp_data[6:0], pins_q[1]};
                    end
                end
                default: begin
                    sda_oe_reg <= sda_oe_reg && bit_reg != 4'h7;
                    if (sym == SYM_STOP) begin
                        cmd_ready <= 1'b1;
                        rsp_valid <= 1'b1;
                    end else begin
                        scl_oe_reg <= 1'b1;
                        if ((sym == SYM_START) || (bit_reg == 4'h8)) begin
                            bit_reg <= 4'h0;
                            if (rsp_nack) begin
                                step_reg <= last_step;
                            end else begin
                                step_reg <= step_reg + 3'h1;
                                tx_reg <= step_byte(
                                    read_reg ? ((step_reg == 3'h3) ?
                                    3'h4 : step_reg + 3'h1) :
                                    step_reg + 3'h1,
                                    reg_addr_reg, wdata_reg);
                            end
                        end else begin
                            bit_reg <= bit_reg + 4'h1;
                            tx_reg <= {tx_reg[6:0], 1'b0};
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_seen <= 1'b0;
        end else begin
            irq_seen <= !pins_q[0];
        end
    end

    assign bus.scl_m_o = 1'b0;
    assign bus.scl_m_oe = scl_oe_reg;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = sda_oe_reg;
endmodule // haptic_port_master

// *** verif/haptic_port_assertions.sv ***
// Bus checker: framing, acks and clocking of the two-wire link.
// Assumes the resolved wires of the joining interface.
`timescale 1ns/100ps
module haptic_port_assertions (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Bus
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_s_oe,
    input wire logic sda_m_oe
);
    logic scl_reg, sda_reg, rw_reg;
    logic [3:0] cnt_reg;
    logic [2:0] idx_reg;
    logic [7:0] sh_reg;
    wire rise = scl && !scl_reg;
    wire strt = scl && scl_reg && sda_reg && !sda;
    wire stp = scl && scl_reg && !sda_reg && sda;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end else begin
            scl_reg <= scl;
            sda_reg <= sda;
        end
    end
    // Bit and byte position within a transfer
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 4'h0;
            idx_reg <= 3'h0;
            rw_reg <= 1'b0;
            sh_reg <= 8'h00;
        end else if (strt || stp) begin
            cnt_reg <= 4'h0;
            idx_reg <= 3'h0;
        end else if (rise) begin
            sh_reg <= {sh_reg[6:0], sda};
            cnt_reg <= (cnt_reg == 4'h8) ? 4'h0 : cnt_reg + 4'h1;
            idx_reg <= (cnt_reg == 4'h8) ? idx_reg + 3'h1 : idx_reg;
            if (cnt_reg == 4'h7 && idx_reg == 3'h0) begin
                rw_reg <= sda;
            end
        end
    end
    property p_steady; $changed(sda_s_oe) |-> !scl; endproperty
    a_steady: assert property (p_steady)
        else $error("data moved, clock high");
    property p_one_drv; !(sda_s_oe && sda_m_oe); endproperty
    a_one_drv: assert property (p_one_drv)
        else $error("two drivers");
    property p_start_free; strt |=> !sda_s_oe [*8]; endproperty
    a_start_free: assert property (p_start_free)
        else $error("drive after start");
    property p_stop_free; stp |=> !sda_s_oe [*8]; endproperty
    a_stop_free: assert property (p_stop_free)
        else $error("drive after stop");
    property p_addr_ack;
        rise && cnt_reg == 4'h8 && idx_reg == 3'h0 && sh_reg[7:1] == 7'h58
        |-> !sda;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address not acked");
    property p_byte_ack;
        rise && cnt_reg == 4'h8 && idx_reg != 3'h0 && !rw_reg |-> !sda;
    endproperty
    a_byte_ack: assert property (p_byte_ack)
        else $error("byte not acked");
    property p_ninth;
        rise && cnt_reg != 4'h8 && (idx_reg == 3'h0 || !rw_reg)
        |-> !sda_s_oe;
    endproperty
    a_ninth: assert property (p_ninth)
        else $error("drive outside ack");
    property p_clk_runs; $fell(scl) |-> ##[1:100] scl; endproperty
    a_clk_runs: assert property (p_clk_runs)
        else $error("clock stuck low");
    c_start: cover property (strt);
    c_read: cover property (rise && rw_reg && idx_reg == 3'h1);
    c_stop: cover property (stp);
endmodule // haptic_port_assertions

// *** verif/haptic_i2c_register_port_bench.sv ***
// Bench: both ends joined, driven by register commands.
// Assumes the shared package and interface.
`timescale 1ns/100ps
module haptic_i2c_register_port_bench;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_read = 1'b0;
    logic [7:0] cmd_reg_addr = 8'h00;
    logic [7:0] cmd_wdata = 8'h00;
    logic [5:0] status_live = 6'h00;
    logic ldo_ok = 1'b1;
    logic [31:0] f0_readback = 32'hA1B2C3D4;
    logic [3:0] engine_state = 4'h9;
    logic cmd_ready, rsp_valid, rsp_nack, irq_seen;
    logic [7:0] rsp_data;
    logic [haptic_port_pkg::REG_COUNT-1:0][7:0] cfg_reg;
    int num_errors = 0;
    int compares = 0;
    localparam logic [15:0] DEFS [5] = '{16'h033F, 16'h0780, 16'h18E1,
        16'h2D38, 16'h3E1B};
    two_wire_bus two_wire_bus_inst ();
    haptic_port_slave #(.IDENTITY_HIGH(1'b1), .IDENTITY_LOW(1'b0))
    haptic_port_slave_inst (.sys_clk(sys_clk), .arst_n(arst_n),
        .bus(two_wire_bus_inst), .status_live(status_live),
        .ldo_ok(ldo_ok), .f0_readback(f0_readback),
        .engine_state(engine_state), .cfg_reg(cfg_reg));
    haptic_port_master #(.QUARTER(8)) haptic_port_master_inst (
        .sys_clk(sys_clk), .arst_n(arst_n), .bus(two_wire_bus_inst),
        .cmd_valid(cmd_valid), .cmd_read(cmd_read),
        .cmd_reg_addr(cmd_reg_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_nack(rsp_nack), .irq_seen(irq_seen));
    haptic_port_assertions haptic_port_assertions_inst (
        .sys_clk(sys_clk), .arst_n(arst_n), .scl(two_wire_bus_inst.scl),
        .sda(two_wire_bus_inst.sda), .sda_s_oe(two_wire_bus_inst.sda_s_oe),
        .sda_m_oe(two_wire_bus_inst.sda_m_oe));
    always #10 sys_clk = !sys_clk;
    task automatic results;
        if (num_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic xfer(input logic rd, input logic [7:0] ra,
                        input logic [7:0] wd);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        cmd_reg_addr <= ra;
        cmd_wdata <= wd;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        repeat (3000) begin
            @(posedge sys_clk);
            if (rsp_valid === 1'b1) break;
        end
        chk("done", 8'h01, {6'h00, rsp_nack, cmd_ready});
    endtask
    task automatic rd(input logic [7:0] ra, input logic [7:0] e);
        xfer(1'b1, ra, 8'h00);
        chk("read", e, rsp_data);
    endtask
    initial begin
        #1000000;
        num_errors++;
        results();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        foreach (DEFS[i]) rd(DEFS[i][15:8], DEFS[i][7:0]);
        rd(8'h02, 8'h10);
        rd(8'h02, 8'h00);
        rd(8'h05, 8'h00);
        xfer(1'b0, 8'h64, 8'hFF);
        rd(8'h64, 8'h02);
        rd(8'h04, 8'h09);
        rd(8'h25, 8'hA1);
        rd(8'h3F, 8'h09);
        xfer(1'b0, 8'h07, 8'h55);
        chk("cfg", 8'h55, cfg_reg[7]);
        xfer(1'b0, 8'h00, 8'h12);
        rd(8'h07, 8'h55);
        xfer(1'b0, 8'h00, 8'hAA);
        rd(8'h07, 8'h80);
        rd(8'h00, 8'h00);
        xfer(1'b0, 8'h03, 8'h3E);
        status_live <= 6'h01;
        repeat (4) @(posedge sys_clk);
        status_live <= 6'h00;
        repeat (12) @(posedge sys_clk);
        chk("irq", 8'h01, {7'h00, irq_seen});
        rd(8'h01, 8'h00);
        rd(8'h02, 8'h01);
        repeat (12) @(posedge sys_clk);
        chk("irq", 8'h00, {7'h00, irq_seen});
        results();
    end
endmodule // haptic_i2c_register_port_bench
